/* File: include/adc_ctrl_pkg.sv */
// Shared constants and types for the SAR converter sequencing block
package adc_ctrl_pkg;
  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL_ONE = 8'h00;
  localparam logic [7:0] ADDR_CTRL_TWO = 8'h04;
  localparam logic [7:0] ADDR_SAMPLE_TIME = 8'h08;
  localparam logic [1:0] BUF_PAGE = 2'h1;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int ONE_ON = 15;
  localparam int ONE_STOP_IN_IDLE = 13;
  localparam int ONE_FORM = 8;
  localparam int ONE_TRIG = 5;
  localparam int ONE_CLRA = 4;
  localparam int ONE_SAMPLE_AUTO_START = 2;
  localparam int ONE_SAMPLE_ENABLE = 1;
  localparam int ONE_DONE = 0;
  localparam int TWO_HALF = 7;
  localparam int TWO_SMPI = 2;
  localparam int TWO_SPLIT = 1;
  // ----------------------------------------
  // Encodings and sizes
  // ----------------------------------------
  localparam logic [2:0] FMT_INT16 = 3'h0;
  localparam logic [2:0] FMT_FRAC16 = 3'h2;
  localparam logic [2:0] FMT_SFRAC16 = 3'h3;
  localparam logic [2:0] FMT_INT32 = 3'h4;
  localparam logic [2:0] FMT_SINT32 = 3'h5;
  localparam logic [2:0] FMT_SFRAC32 = 3'h7;
  localparam logic [2:0] TRIG_MANUAL = 3'h0;
  localparam logic [2:0] TRIG_PIN = 3'h1;
  localparam logic [2:0] TRIG_TIMER = 3'h2;
  localparam logic [2:0] TRIG_CHARGE = 3'h3;
  localparam logic [2:0] TRIG_AUTO = 3'h7;
  localparam int BUF_DEPTH = 16;
  localparam int RES_W = 10;
  localparam logic [4:0] SAMC_MIN = 5'h01;
  localparam logic [4:0] SAMC_RESET = 5'h01;
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_SAMPLE = 2'b01,
    SEQ_CONVERT = 2'b10
  } seq_t;
endpackage

/* File: core/sar_adc_sample_convert_control.sv */
// Sample and convert sequencer with control registers and result buffer
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Converter runs only while enable is set
// - Stop-in-idle halts module during Idle mode
// - 32-bit formats: signed fraction, signed, unsigned integer
// - 16-bit formats: signed fraction, fraction, integer
// - Trigger 111 uses internal sample counter
// - Triggers 011/010/001: charge unit, timer, pin
// - Manual trigger: clearing sample-enable starts conversion
// - Other triggers: hardware clears sample-enable itself
// - Auto-start resamples after each conversion
// - Without auto-start, software write starts sampling
// - Sample-enable reads 1 while acquiring
// - Done flag set when conversion finishes
// - Done cleared by writing 0; writing 1 leaves it as it is
// - Done cleared when a conversion starts
// - Stop-on-first-irq clears auto-start at interrupt
// - Otherwise keep converting, overwriting the buffer
// - Upper half of control one reads zero
// - Sixteen-word result buffer
// - Interrupt every interval plus one sequences
// - Split mode: two alternating eight-word halves
// - Half indicator shows the half being filled
// - Auto sample time in conversion clock periods
module sar_adc_sample_convert_control
  import adc_ctrl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  input wire logic idleMode,
  input wire logic tadTick,
  input wire logic timerPeriodMatch,
  input wire logic chargeUnitTrigger,
  input wire logic extTriggerPin,
  input wire logic convDone,
  input wire logic [RES_W-1:0] convData,
  output logic shaSample,
  output logic convStart,
  output logic adcIrq
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic on;
    logic stopInIdle;
    logic [2:0] outputFormat;
    logic [2:0] triggerSource;
    logic stopOnFirstIrq;
    logic sampleAutoStart;
    logic done;
    logic [3:0] interruptInterval;
    logic bufferSplit;
    logic [4:0] autoSampleTime;
    seq_t seq;
    logic [4:0] sampleCount;
    logic [3:0] writePtr;
    logic [3:0] seqCount;
    logic convStart;
    logic irqPulse;
    logic [2:0] pinSync;
    logic [31:0] rdata;
    logic [BUF_DEPTH-1:0][31:0] resultBuf;
  } state_t;

  state_t s;
  state_t next_s;
  logic [1:0] rstSync;
  logic rstnInt;
  logic running;
  logic wrOne;
  logic trigHit;
  logic accept;
  logic irqNow;
  logic [4:0] samcEff;
  logic [4:0] countInc;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    return a == off;
  endfunction

  function automatic logic isBuf(input logic [ADDR_W-1:0] a);
    return a[7:6] == BUF_PAGE;
  endfunction

  // Unsigned code re-centred around mid-scale for the signed formats
  function automatic logic [31:0] fmt(input logic [RES_W-1:0] d, input logic [2:0] f);
    logic [RES_W-1:0] sv;
    sv = {~d[RES_W-1], d[RES_W-2:0]};
    unique case (f)
      FMT_SFRAC32: fmt = {sv, 22'h000000};
      FMT_SINT32: fmt = {{22{sv[RES_W-1]}}, sv};
      FMT_INT32: fmt = {22'h000000, d};
      FMT_SFRAC16: fmt = {16'h0000, sv, 6'h00};
      FMT_FRAC16: fmt = {16'h0000, d, 6'h00};
      default: fmt = {22'h000000, d};
    endcase
  endfunction

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstnInt = rstSync[1];

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_s = s;
    next_s.convStart = 1'b0;
    next_s.irqPulse = 1'b0;
    next_s.rdata = 32'h00000000;
    next_s.pinSync = {s.pinSync[1:0], extTriggerPin};
    running = s.on && !(s.stopInIdle && idleMode);
    wrOne = regWrite && hit(regAddr, ADDR_CTRL_ONE);
    samcEff = (s.autoSampleTime < SAMC_MIN) ? SAMC_MIN : s.autoSampleTime;
    countInc = s.sampleCount + 5'h01;
    unique case (s.triggerSource)
      TRIG_AUTO: trigHit = tadTick && (countInc >= samcEff);
      TRIG_CHARGE: trigHit = chargeUnitTrigger;
      TRIG_TIMER: trigHit = timerPeriodMatch;
      TRIG_PIN: trigHit = s.pinSync[1] && !s.pinSync[2];
      TRIG_MANUAL: trigHit = wrOne && !regWdata[ONE_SAMPLE_ENABLE];
      default: trigHit = 1'b0;
    endcase
    accept = running && (s.seq == SEQ_CONVERT) && convDone;
    irqNow = accept && (s.seqCount == s.interruptInterval);

    if (wrOne) begin
      next_s.on = regWdata[ONE_ON];
      next_s.stopInIdle = regWdata[ONE_STOP_IN_IDLE];
      next_s.outputFormat = regWdata[ONE_FORM+:3];
      next_s.triggerSource = regWdata[ONE_TRIG+:3];
      next_s.stopOnFirstIrq = regWdata[ONE_CLRA];
      next_s.sampleAutoStart = regWdata[ONE_SAMPLE_AUTO_START];
      if (!regWdata[ONE_DONE]) begin
        next_s.done = 1'b0;
      end
    end
    if (regWrite && hit(regAddr, ADDR_CTRL_TWO)) begin
      next_s.interruptInterval = regWdata[TWO_SMPI+:4];
      next_s.bufferSplit = regWdata[TWO_SPLIT];
      next_s.writePtr = 4'h0;
      next_s.seqCount = 4'h0;
    end
    if (regWrite && hit(regAddr, ADDR_SAMPLE_TIME)) begin
      next_s.autoSampleTime = regWdata[4:0];
    end

    unique case (s.seq)
      SEQ_IDLE: begin
        if (wrOne && regWdata[ONE_SAMPLE_ENABLE] && !s.sampleAutoStart) begin
          next_s.seq = SEQ_SAMPLE;
        end else if (s.sampleAutoStart) begin
          next_s.seq = SEQ_SAMPLE;
        end
      end
      SEQ_SAMPLE: begin
        if (tadTick && s.triggerSource == TRIG_AUTO) begin
          next_s.sampleCount = countInc;
        end
        if (trigHit) begin
          next_s.seq = SEQ_CONVERT;
          next_s.convStart = 1'b1;
          next_s.sampleCount = 5'h00;
          next_s.done = 1'b0;
        end
      end
      SEQ_CONVERT: begin
        if (convDone) begin
          next_s.resultBuf[s.writePtr] = fmt(convData, s.outputFormat);
          next_s.done = 1'b1;
          next_s.seqCount = s.seqCount + 4'h1;
          if (s.bufferSplit) begin
            next_s.writePtr = {s.writePtr[3], s.writePtr[2:0] + 3'h1};
          end else begin
            next_s.writePtr = s.writePtr + 4'h1;
          end
          if (irqNow) begin
            next_s.irqPulse = 1'b1;
            next_s.seqCount = 4'h0;
            // Each interrupt restarts the region so software finds a whole block
            next_s.writePtr = {s.bufferSplit & ~s.writePtr[3], 3'h0};
            if (s.stopOnFirstIrq) begin
              next_s.sampleAutoStart = 1'b0;
            end
          end
          if (next_s.sampleAutoStart) begin
            next_s.seq = SEQ_SAMPLE;
          end else begin
            next_s.seq = SEQ_IDLE;
          end
        end
      end
      default: next_s.seq = SEQ_IDLE;
    endcase

    // Disabling abandons any conversion; the buffer is left as it was
    if (!running) begin
      next_s = s;
      next_s.convStart = 1'b0;
      next_s.irqPulse = 1'b0;
      next_s.rdata = 32'h00000000;
      next_s.pinSync = {s.pinSync[1:0], extTriggerPin};
      if (wrOne) begin
        next_s.on = regWdata[ONE_ON];
        next_s.stopInIdle = regWdata[ONE_STOP_IN_IDLE];
        next_s.outputFormat = regWdata[ONE_FORM+:3];
        next_s.triggerSource = regWdata[ONE_TRIG+:3];
        next_s.stopOnFirstIrq = regWdata[ONE_CLRA];
        next_s.sampleAutoStart = regWdata[ONE_SAMPLE_AUTO_START];
        if (!regWdata[ONE_DONE]) begin
          next_s.done = 1'b0;
        end
      end
      if (regWrite && hit(regAddr, ADDR_CTRL_TWO)) begin
        next_s.interruptInterval = regWdata[TWO_SMPI+:4];
        next_s.bufferSplit = regWdata[TWO_SPLIT];
        next_s.writePtr = 4'h0;
        next_s.seqCount = 4'h0;
      end
      if (regWrite && hit(regAddr, ADDR_SAMPLE_TIME)) begin
        next_s.autoSampleTime = regWdata[4:0];
      end
      next_s.seq = SEQ_IDLE;
      next_s.sampleCount = 5'h00;
    end

    // ----------------------------------------
    // Register read, data valid one cycle later
    // ----------------------------------------
    if (regRead) begin
      if (hit(regAddr, ADDR_CTRL_ONE)) begin
        next_s.rdata[ONE_ON] = s.on;
        next_s.rdata[ONE_STOP_IN_IDLE] = s.stopInIdle;
        next_s.rdata[ONE_FORM+:3] = s.outputFormat;
        next_s.rdata[ONE_TRIG+:3] = s.triggerSource;
        next_s.rdata[ONE_CLRA] = s.stopOnFirstIrq;
        next_s.rdata[ONE_SAMPLE_AUTO_START] = s.sampleAutoStart;
        next_s.rdata[ONE_SAMPLE_ENABLE] = (s.seq == SEQ_SAMPLE);
        next_s.rdata[ONE_DONE] = s.done;
      end else if (hit(regAddr, ADDR_CTRL_TWO)) begin
        next_s.rdata[TWO_HALF] = s.bufferSplit & s.writePtr[3];
        next_s.rdata[TWO_SMPI+:4] = s.interruptInterval;
        next_s.rdata[TWO_SPLIT] = s.bufferSplit;
      end else if (hit(regAddr, ADDR_SAMPLE_TIME)) begin
        next_s.rdata[4:0] = s.autoSampleTime;
      end else if (isBuf(regAddr)) begin
        next_s.rdata = s.resultBuf[regAddr[5:2]];
      end
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rstnInt) begin
    if (!rstnInt) begin
      s <= '0;
      s.seq <= SEQ_IDLE;
      s.autoSampleTime <= SAMC_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign regRdata = s.rdata;
  assign shaSample = s.seq[0];
  assign convStart = s.convStart;
  assign adcIrq = s.irqPulse;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstnInt);

  property p_off_idle;
    !s.on |=> (s.seq == SEQ_IDLE) && !shaSample && !convStart;
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("Sequencer active while disabled");

  property p_idle_stop;
    (s.stopInIdle && idleMode) |=> (s.seq == SEQ_IDLE) && !adcIrq;
  endproperty
  a_idle_stop: assert property (p_idle_stop) else $error("Running in Idle with stop set");

  property p_format;
    accept |=> s.resultBuf[$past(s.writePtr)] == fmt($past(convData), $past(s.outputFormat));
  endproperty
  a_format: assert property (p_format) else $error("Stored result format wrong");

  property p_hw_trigger;
    (running && s.seq == SEQ_SAMPLE && trigHit) |=> convStart && (s.seq == SEQ_CONVERT);
  endproperty
  a_hw_trigger: assert property (p_hw_trigger) else $error("Trigger did not start conversion");

  property p_manual_end;
    (running && s.seq == SEQ_SAMPLE && s.triggerSource == TRIG_MANUAL && wrOne
      && !regWdata[ONE_SAMPLE_ENABLE]) |=> convStart ##1 !convStart;
  endproperty
  a_manual_end: assert property (p_manual_end) else $error("Manual end of sampling lost");

  property p_auto_restart;
    (accept && s.sampleAutoStart && !(irqNow && s.stopOnFirstIrq) && !wrOne)
      |=> shaSample;
  endproperty
  a_auto_restart: assert property (p_auto_restart) else $error("No automatic resample");

  property p_done_cycle;
    accept |=> s.done;
  endproperty
  a_done_cycle: assert property (p_done_cycle) else $error("Done flag not held");

  property p_done_clear;
    convStart |-> !s.done;
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("Done set at conversion start");

  property p_first_irq;
    (irqNow && s.stopOnFirstIrq && !wrOne) |=> adcIrq && !s.sampleAutoStart && !shaSample;
  endproperty
  a_first_irq: assert property (p_first_irq) else $error("Auto-start kept after interrupt");

  property p_half_swap;
    (irqNow && s.bufferSplit && !regWrite) |=> s.writePtr[3] != $past(s.writePtr[3]);
  endproperty
  a_half_swap: assert property (p_half_swap) else $error("Buffer half did not alternate");

  property p_upper_zero;
    (regRead && hit(regAddr, ADDR_CTRL_ONE)) |=> regRdata[31:16] == 16'h0000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("Reserved bits read nonzero");

  c_auto_loop: cover property (accept && s.sampleAutoStart ##1 shaSample);
  c_irq_split: cover property (adcIrq && s.bufferSplit);
  c_pin_trig: cover property (convStart && s.triggerSource == TRIG_PIN);
  c_counter: cover property (convStart && s.triggerSource == TRIG_AUTO);

endmodule // sar_adc_sample_convert_control
`default_nettype wire

/* File: testbench/adc_core_model.sv */
// Behavioural converter core that answers each start pulse after a fixed latency
`timescale 1ns/1ps
`default_nettype none
module adc_core_model #(
  parameter int LAT = 8
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic convStart,
  input wire logic [9:0] sampleIn,
  output logic convDone,
  output logic [9:0] convData
);
  int left;
  // ----------------------------------------
  // Conversion timing
  // ----------------------------------------
  // Data is scrambled outside the done pulse, so a stale capture cannot pass
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      left <= 0;
      convDone <= 1'h0;
      convData <= 10'h000;
    end else begin
      convDone <= (left == 1);
      convData <= (left == 1) ? sampleIn : ~convData;
      if (convStart) begin
        left <= LAT;
      end else if (left > 0) begin
        left <= left - 1;
      end
    end
  end
endmodule // adc_core_model
`default_nettype wire

/* File: testbench/testbench.sv */
// Self-checking bench for the sample and convert sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin testsRun++; if ((g) !== (e)) begin errCount++; \
  $display("[FAIL] %s exp=%0h got=%0h", nm, e, g); end end
module testbench;
  import adc_ctrl_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam logic [31:0] EN1 = 32'h00008000;
  logic clk_sys = 1'h0;
  logic rstn = 1'h0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h00000000;
  logic regWrite = 1'h0, regRead = 1'h0, idleMode = 1'h0, tadTick = 1'h0;
  logic timerPeriodMatch = 1'h0, chargeUnitTrigger = 1'h0, extTriggerPin = 1'h0;
  logic [31:0] regRdata;
  logic convDone, shaSample, convStart, adcIrq;
  logic [9:0] convData;
  logic [9:0] sampleIn = 10'h000;
  logic [31:0] seed = 32'h0000002E;
  logic [2:0] fmts [6] = '{FMT_INT16, FMT_FRAC16, FMT_SFRAC16, FMT_INT32, FMT_SINT32, FMT_SFRAC32};
  int errCount = 0, testsRun = 0, starts = 0, irqs = 0, dones = 0, ticks = 0, lastTicks = 0;
  // ----------------------------------------
  // Design and converter core
  // ----------------------------------------
  sar_adc_sample_convert_control u_dut (
    .clk_sys(clk_sys), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .idleMode(idleMode),
    .tadTick(tadTick), .timerPeriodMatch(timerPeriodMatch),
    .chargeUnitTrigger(chargeUnitTrigger), .extTriggerPin(extTriggerPin),
    .convDone(convDone), .convData(convData), .shaSample(shaSample),
    .convStart(convStart), .adcIrq(adcIrq)
  );
  adc_core_model #(.LAT(8)) u_model (
    .clk_sys(clk_sys), .rstn(rstn), .convStart(convStart), .sampleIn(sampleIn),
    .convDone(convDone), .convData(convData)
  );
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) tadTick <= ~tadTick;
  // Counting on the falling edge keeps the counters clear of the sampling edge
  always @(negedge clk_sys) begin
    if (convStart) begin
      starts++;
      lastTicks = ticks;
      ticks = 0;
    end
    if (shaSample && tadTick) ticks++;
    if (adcIrq) irqs++;
    if (convDone) dones++;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [9:0] rnd10();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[9:0];
  endfunction
  function automatic logic [31:0] fmtExp(input logic [2:0] f, input logic [9:0] d);
    logic [9:0] s;
    s = {~d[9], d[8:0]};
    case (f)
      FMT_FRAC16: fmtExp = {16'h0000, d, 6'h00};
      FMT_SFRAC16: fmtExp = {16'h0000, s, 6'h00};
      FMT_SINT32: fmtExp = {{22{s[9]}}, s};
      FMT_SFRAC32: fmtExp = {s, 22'h000000};
      default: fmtExp = {22'h000000, d};
    endcase
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    regWrite <= 1'h1;
    regAddr <= a;
    regWdata <= v;
    @(posedge clk_sys);
    regWrite <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    regRead <= 1'h1;
    regAddr <= a;
    @(posedge clk_sys);
    regRead <= 1'h0;
    #1 v = regRdata;
  endtask
  task automatic waitFor(ref int c, input int t);
    for (int k = 0; k < 300 && c < t; k++) @(negedge clk_sys);
    `CHK("eventCount", t, c)
  endtask
  task automatic fire(input int t);
    @(posedge clk_sys);
    extTriggerPin <= (t == 1);
    timerPeriodMatch <= (t == 2);
    chargeUnitTrigger <= (t == 3);
    @(posedge clk_sys);
    timerPeriodMatch <= 1'h0;
    chargeUnitTrigger <= 1'h0;
    repeat (3) @(posedge clk_sys);
    extTriggerPin <= 1'h0;
  endtask
  // Done bit is always written as 1 so that only the hardware moves it
  task automatic manualConv(input logic [2:0] f, input logic [9:0] d);
    logic [31:0] rv;
    int s;
    int sd;
    s = starts;
    sd = dones;
    sampleIn <= d;
    // A sample request is only honoured once the module already runs
    wr(ADDR_CTRL_ONE, EN1 | {21'h000000, f, 8'h01});
    wr(ADDR_CTRL_ONE, EN1 | {21'h000000, f, 8'h03});
    repeat (2) @(negedge clk_sys);
    `CHK("sampling", 1'h1, shaSample)
    wr(ADDR_CTRL_ONE, EN1 | {21'h000000, f, 8'h01});
    waitFor(starts, s + 1);
    `CHK("holdAfterClear", 1'h0, shaSample)
    rd(ADDR_CTRL_ONE, rv);
    `CHK("doneAtStart", 1'h0, rv[ONE_DONE])
    waitFor(dones, sd + 1);
    rd(ADDR_CTRL_ONE, rv);
    `CHK("doneSet", 1'h1, rv[ONE_DONE])
  endtask
  task automatic tallyAndFinish();
    $display("comparisons %0d, mismatches %0d", testsRun, errCount);
    if (errCount == 0 && testsRun > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #100000;
    errCount++;
    tallyAndFinish();
  end
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    logic [31:0] rv;
    logic [9:0] d;
    int s;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'h1;
    repeat (3) @(posedge clk_sys);
    rd(ADDR_CTRL_ONE, rv);
    `CHK("ctrlOneReset", 32'h00000000, rv)
    rd(ADDR_SAMPLE_TIME, rv);
    `CHK("sampleTimeReset", 32'h00000001, rv)
    rd(8'h20, rv);
    `CHK("unmapped", 32'h00000000, rv)
    wr(ADDR_CTRL_ONE, 32'h00000002);
    repeat (4) @(negedge clk_sys);
    `CHK("offNoSample", 1'h0, shaSample)
    rd({BUF_PAGE, 6'h00}, rv);
    `CHK("offBufferKept", 32'h00000000, rv)
    for (int i = 0; i < 6; i++) begin
      d = rnd10();
      s = irqs;
      manualConv(fmts[i], d);
      rd({BUF_PAGE, 6'h00}, rv);
      `CHK("format", fmtExp(fmts[i], d), rv)
      `CHK("irqEvery", s + 1, irqs)
    end
    wr(ADDR_CTRL_ONE, EN1);
    rd(ADDR_CTRL_ONE, rv);
    `CHK("doneClear", 1'h0, rv[ONE_DONE])
    wr(ADDR_CTRL_ONE, EN1 | 32'h00000001);
    rd(ADDR_CTRL_ONE, rv);
    `CHK("doneNoSet", 1'h0, rv[ONE_DONE])
    for (int t = 1; t < 7; t++) begin
      s = starts;
      wr(ADDR_CTRL_ONE, EN1 | 32'(t << 5) | 32'h00000003);
      if (t < 4) begin
        fire(t);
        waitFor(starts, s + 1);
        `CHK("trigClearsSample", 1'h0, shaSample)
        waitFor(dones, dones + 1);
      end else begin
        fire(1);
        fire(2);
        fire(3);
        repeat (20) @(negedge clk_sys);
        `CHK("reservedNoStart", s, starts)
        if (t == 6) begin
          wr(ADDR_CTRL_ONE, 32'h00000000);
        end
      end
    end
    wr(ADDR_SAMPLE_TIME, 32'h00000003);
    s = starts;
    wr(ADDR_CTRL_ONE, EN1 | 32'h000000E4);
    waitFor(starts, s + 3);
    `CHK("autoTicks", 3, lastTicks)
    s = irqs;
    wr(ADDR_CTRL_ONE, EN1 | 32'h000000F4);
    waitFor(irqs, s + 1);
    repeat (4) @(negedge clk_sys);
    s = starts;
    rd(ADDR_CTRL_ONE, rv);
    `CHK("autoCleared", 1'h0, rv[ONE_SAMPLE_AUTO_START])
    repeat (40) @(negedge clk_sys);
    `CHK("stoppedAfterIrq", s, starts)
    // Running first, so a broken stop-in-idle would visibly start sampling
    wr(ADDR_CTRL_ONE, EN1 | 32'h00002000);
    idleMode <= 1'h1;
    wr(ADDR_CTRL_ONE, EN1 | 32'h00002002);
    repeat (4) @(negedge clk_sys);
    `CHK("idleStops", 1'h0, shaSample)
    // Reserved trigger, so the later disable cannot turn sampling into a conversion
    wr(ADDR_CTRL_ONE, EN1 | 32'h00000080);
    wr(ADDR_CTRL_ONE, EN1 | 32'h00000082);
    repeat (3) @(negedge clk_sys);
    `CHK("idleRuns", 1'h1, shaSample)
    wr(ADDR_CTRL_ONE, 32'h00000000);
    idleMode <= 1'h0;
    wr(ADDR_CTRL_TWO, 32'h0000000A);
    s = irqs;
    d = rnd10();
    manualConv(FMT_INT16, ~d);
    manualConv(FMT_INT16, d);
    `CHK("irqHeld", s, irqs)
    manualConv(FMT_INT16, ~d);
    `CHK("irqThird", s + 1, irqs)
    rd(ADDR_CTRL_TWO, rv);
    `CHK("halfSwap", 1'h1, rv[TWO_HALF])
    rd({BUF_PAGE, 6'h04}, rv);
    `CHK("splitEntry", fmtExp(FMT_INT16, d), rv)
    tallyAndFinish();
  end
endmodule // testbench
`default_nettype wire
